/* cgm_board_model.sv */
// board-side logic that drives or samples the two general-purpose pins
`timescale 1ns/1ps
`default_nettype none
module cgm_board_model (
	input wire logic clock,
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe_n,
	input wire logic [1:0] drv_en,
	input wire logic [1:0] drv_val,
	output logic [1:0] pin_level
);
	logic flip_reg = 1'b0;
	always @(posedge clock)
	begin
		flip_reg <= !flip_reg;
	end
	// released and undriven pins wander each cycle
	always_comb
	begin
		for (int b = 0; b < 2; b++)
		begin
			if (!pin_oe_n[b])
				pin_level[b] = pin_out[b];
			else if (drv_en[b])
				pin_level[b] = drv_val[b];
			else
				pin_level[b] = flip_reg ^ b[0];
		end
	end
endmodule
`default_nettype wire

/* cgm_gpio_mux.sv */
// function multiplexer for the two general-purpose pins
// Functional notes
// - upper nibble sets second pin role, lower nibble sets first pin role
// - status outputs follow internal status polarity unless inversion enabled
// - invert bit set inverts every driven output pin, both together
// - pin in input role replaces its internal control bit
// - code 0001: pin high forces holdover, low lets first PLL lock
// - code 0010: pin high forces first PLL control voltage mid-supply
// - lower nibble 0111: both pins select clock input manually, 00 or 01
// - pin-driven manual selection overrides register manual/auto select bits
// - code 1000: pin high when first PLL locked
// - code 1001: pin high when second PLL locked
// - code 1010: pin high only while both PLLs locked
// - code 1011: pin low on loss of signal on any enabled input
// - code 1100: pin low while in holdover
// - code 1101: pin high while any unmasked latched status bit set
// - lower nibble 1111: both pins show selected clock input code
// - pins sampled at reset release; defaults 1011 first, 1010 second
// - zero mask bit keeps latched bit off interrupt pin
`timescale 1ns/1ps
`default_nettype none
module cgm_gpio_mux #(
	parameter int NUM_INPUTS = 2,
	parameter int NUM_LATCHED = 8
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic cfg_wr_en,
	input wire logic [7:0] cfg_wr_data,
	output logic [7:0] cfg_rd_data,
	input wire logic pin_output_invert,
	input wire logic pll0_locked,
	input wire logic pll1_locked,
	input wire logic [NUM_INPUTS-1:0] clk_los,
	input wire logic [NUM_INPUTS-1:0] clock_input_disable,
	input wire logic in_holdover,
	input wire logic [NUM_LATCHED-1:0] latched_status,
	input wire logic [NUM_LATCHED-1:0] per_condition_irq_mask,
	input wire logic [1:0] selected_clock,
	input wire logic reg_holdover_force,
	input wire logic pll0_vctrl_force_bit,
	input wire logic [1:0] manual_auto_select_bits,
	input wire logic [1:0] reg_clock_select,
	output logic holdover_force,
	output logic vctrl_force,
	output logic manual_select_override,
	output logic [1:0] mode_select,
	output logic [1:0] clock_select,
	output logic strap_done,
	output logic [1:0] strap_value,
	input wire logic [1:0] pin_in,
	output logic [1:0] pin_out,
	output logic [1:0] pin_oe_n
);
	typedef struct packed {
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [7:0] func;
		logic [1:0] pin_out;
		logic [1:0] oe_n;
		logic hold_force;
		logic vctrl_force;
		logic man_ovr;
		logic [1:0] man_code;
		logic [1:0] eff_mode;
		logic [1:0] eff_sel;
		logic [1:0] strap_cnt;
		logic strap_done;
		logic [1:0] strap_value;
	} cgm_state_t;

	localparam cgm_state_t STATE_RESET = '{
		sync1: 2'h0,
		sync2: 2'h0,
		func: cgm_pkg::FUNC_RESET,
		pin_out: 2'h0,
		oe_n: 2'h3,
		hold_force: 1'b0,
		vctrl_force: 1'b0,
		man_ovr: 1'b0,
		man_code: 2'h0,
		eff_mode: 2'h0,
		eff_sel: 2'h0,
		strap_cnt: 2'h0,
		strap_done: 1'b0,
		strap_value: 2'h0
	};

	cgm_state_t r_reg;
	cgm_state_t r_next;

	logic [cgm_pkg::ST_W-1:0] status_vec;
	logic global_in;
	logic global_out;
	logic [1:0] drive_v;
	logic [1:0] level_v;
	logic [1:0] hold_hit;
	logic [1:0] vctrl_hit;
	logic sel_legal;

	assign status_vec[cgm_pkg::ST_LOCK0] = pll0_locked;
	assign status_vec[cgm_pkg::ST_LOCK1] = pll1_locked;
	assign status_vec[cgm_pkg::ST_BOTH] = pll0_locked & pll1_locked;
	assign status_vec[cgm_pkg::ST_NO_ALARM] = ~|(clk_los & ~clock_input_disable);
	assign status_vec[cgm_pkg::ST_NO_HOLD] = ~in_holdover;
	assign status_vec[cgm_pkg::ST_IRQ] = |(latched_status & per_condition_irq_mask);

	assign global_in = (r_reg.func[cgm_pkg::PIN0_LSB +: cgm_pkg::NIB_W] == cgm_pkg::FN_MAN_SELECT);
	assign global_out = (r_reg.func[cgm_pkg::PIN0_LSB +: cgm_pkg::NIB_W] == cgm_pkg::FN_SEL_OUT);
	assign sel_legal = ((r_reg.sync2 & cgm_pkg::CLKSEL_RSV_MASK) == 2'h0);

	cgm_role_if role_bus [cgm_pkg::PIN_COUNT] ();

	genvar gi;
	generate
		for (gi = 0; gi < cgm_pkg::PIN_COUNT; gi++)
		begin : g_pin
			assign role_bus[gi].code = r_reg.func[gi*cgm_pkg::NIB_W +: cgm_pkg::NIB_W];
			assign role_bus[gi].status = status_vec;
			cgm_pin_role u_role (
				.rif(role_bus[gi])
			);
			// global codes on the low nibble override either pin's own role
			assign drive_v[gi] = global_out | (~global_in & role_bus[gi].drive);
			assign level_v[gi] = global_out ? selected_clock[gi] : role_bus[gi].level;
			assign hold_hit[gi] = ~global_in & ~global_out & role_bus[gi].hold_role;
			assign vctrl_hit[gi] = ~global_in & ~global_out & role_bus[gi].vctrl_role;
		end
	endgenerate

	always_comb
	begin
		r_next = r_reg;
		r_next.sync1 = pin_in;
		r_next.sync2 = r_reg.sync1;
		if (cfg_wr_en)
		begin
			r_next.func = cfg_wr_data;
		end
		r_next.pin_out = drive_v & (level_v ^ {2{pin_output_invert}});
		r_next.oe_n = ~drive_v;
		// conflicting levels on a shared input role are undefined; pins are or-ed
		if (|hold_hit)
		begin
			r_next.hold_force = |(hold_hit & r_reg.sync2);
		end
		else
		begin
			r_next.hold_force = reg_holdover_force;
		end
		if (|vctrl_hit)
		begin
			r_next.vctrl_force = |(vctrl_hit & r_reg.sync2);
		end
		else
		begin
			r_next.vctrl_force = pll0_vctrl_force_bit;
		end
		r_next.man_ovr = global_in;
		if (global_in && sel_legal)
		begin
			r_next.man_code = r_reg.sync2;
		end
		if (global_in)
		begin
			r_next.eff_mode = cgm_pkg::MANUAL_MODE_CODE;
			r_next.eff_sel = sel_legal ? r_reg.sync2 : r_reg.man_code;
		end
		else
		begin
			r_next.eff_mode = manual_auto_select_bits;
			r_next.eff_sel = reg_clock_select;
		end
		// strap capture once the synchroniser holds post-release pin levels
		if (!r_reg.strap_done)
		begin
			if (r_reg.strap_cnt == cgm_pkg::STRAP_WAIT)
			begin
				r_next.strap_done = 1'b1;
				r_next.strap_value = r_reg.sync2;
			end
			else
			begin
				r_next.strap_cnt = r_reg.strap_cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			r_reg <= STATE_RESET;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign cfg_rd_data = r_reg.func;
	assign pin_out = r_reg.pin_out;
	assign pin_oe_n = r_reg.oe_n;
	assign holdover_force = r_reg.hold_force;
	assign vctrl_force = r_reg.vctrl_force;
	assign manual_select_override = r_reg.man_ovr;
	assign mode_select = r_reg.eff_mode;
	assign clock_select = r_reg.eff_sel;
	assign strap_done = r_reg.strap_done;
	assign strap_value = r_reg.strap_value;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	AST_PIN1_ROLE_FROM_UPPER: assert property (
		(r_reg.func[7:4] == cgm_pkg::FN_LOCK1) && !global_in && !global_out
		|=> !pin_oe_n[1] && (pin_out[1] == ($past(pll1_locked) ^ $past(pin_output_invert))))
		else $error("second pin does not follow upper nibble role");

	AST_PIN0_LOCK0: assert property (
		(r_reg.func[3:0] == cgm_pkg::FN_LOCK0)
		|=> !pin_oe_n[0] && (pin_out[0] == ($past(pll0_locked) ^ $past(pin_output_invert))))
		else $error("first pin lock detect wrong");

	AST_BOTH_LOCK_INVERT: assert property (
		(r_reg.func[7:4] == cgm_pkg::FN_LOCK_BOTH) && !global_in && !global_out && pin_output_invert
		|=> pin_out[1] == !($past(pll0_locked) && $past(pll1_locked)))
		else $error("both-lock output not inverted correctly");

	AST_ALARM_LOW: assert property (
		(r_reg.func[3:0] == cgm_pkg::FN_NO_ALARM) && !pin_output_invert && |(clk_los & ~clock_input_disable)
		|=> !pin_out[0] && !pin_oe_n[0])
		else $error("activity alarm not shown low");

	AST_HOLD_STATE_OUT: assert property (
		(r_reg.func[7:4] == cgm_pkg::FN_NO_HOLD) && !global_in && !global_out
		|=> pin_out[1] == ($past(pin_output_invert) ^ !$past(in_holdover)))
		else $error("holdover state output wrong");

	AST_IRQ_MASKED: assert property (
		(r_reg.func[3:0] == cgm_pkg::FN_IRQ) && !pin_output_invert
		&& ((latched_status & per_condition_irq_mask) == '0)
		|=> !pin_out[0])
		else $error("masked or cleared sources still raise interrupt pin");

	AST_IRQ_SET: assert property (
		(r_reg.func[3:0] == cgm_pkg::FN_IRQ) && !pin_output_invert
		&& |(latched_status & per_condition_irq_mask)
		|=> pin_out[0] && !pin_oe_n[0])
		else $error("unmasked latched bit does not raise interrupt pin");

	AST_SEL_OUT: assert property (
		global_out
		|=> (pin_oe_n == 2'h0) && (pin_out == ($past(selected_clock) ^ {2{$past(pin_output_invert)}})))
		else $error("selected clock code not shown on pins");

	AST_HOLD_FORCE_PIN: assert property (
		(r_reg.func[3:0] == cgm_pkg::FN_HOLD_FORCE) && (r_reg.func[7:4] != cgm_pkg::FN_HOLD_FORCE)
		|=> pin_oe_n[0] && (holdover_force == $past(r_reg.sync2[0])))
		else $error("holdover force not taken from first pin");

	AST_VCTRL_FORCE_PIN: assert property (
		(r_reg.func[7:4] == cgm_pkg::FN_VCTRL_FORCE) && !global_in && !global_out
		&& (r_reg.func[3:0] != cgm_pkg::FN_VCTRL_FORCE)
		|=> vctrl_force == $past(r_reg.sync2[1]))
		else $error("control voltage force register bit not replaced by pin");

	AST_MAN_SELECT: assert property (
		global_in && sel_legal
		|=> manual_select_override && pin_oe_n == 2'h3
		&& (clock_select == $past(r_reg.sync2)) && (mode_select == cgm_pkg::MANUAL_MODE_CODE))
		else $error("pin manual selection not taking precedence");

	AST_RESERVED_IDLE: assert property (
		(r_reg.func[3:0] == 4'h0) || (r_reg.func[3:0] == 4'he)
		|=> pin_oe_n[0] && !pin_out[0])
		else $error("reserved code drives first pin");

	AST_STRAP_CAPTURE: assert property (
		!r_reg.strap_done && (r_reg.strap_cnt == cgm_pkg::STRAP_WAIT)
		|=> strap_done && (strap_value == $past(r_reg.sync2)) ##1 $stable(strap_value))
		else $error("strap level not captured after reset release");

	AST_PIN0_LOCK1: assert property (
		(r_reg.func[3:0] == cgm_pkg::FN_LOCK1)
		|=> !pin_oe_n[0] && (pin_out[0] == ($past(pll1_locked) ^ $past(pin_output_invert))))
		else $error("first pin second lock detect wrong");

	AST_HOLD_REG_BIT: assert property (
		(r_reg.func[3:0] != cgm_pkg::FN_HOLD_FORCE)
		&& ((r_reg.func[7:4] != cgm_pkg::FN_HOLD_FORCE) || global_in || global_out)
		|=> holdover_force == $past(reg_holdover_force))
		else $error("holdover force register bit not used without pin role");

	AST_VCTRL_REG_BIT: assert property (
		(r_reg.func[3:0] != cgm_pkg::FN_VCTRL_FORCE)
		&& ((r_reg.func[7:4] != cgm_pkg::FN_VCTRL_FORCE) || global_in || global_out)
		|=> vctrl_force == $past(pll0_vctrl_force_bit))
		else $error("control voltage force register bit not used without pin role");

	AST_VCTRL_PIN_RELEASED: assert property (
		(r_reg.func[7:4] == cgm_pkg::FN_VCTRL_FORCE) && !global_in && !global_out
		|=> pin_oe_n[1] && !pin_out[1])
		else $error("control voltage force pin is driven");

	AST_MAN_RESERVED_KEEP: assert property (
		global_in && !sel_legal && manual_select_override
		|=> manual_select_override && (clock_select == $past(clock_select)))
		else $error("reserved manual code changed the clock choice");

	AST_REG_SELECT: assert property (
		!global_in
		|=> !manual_select_override && (mode_select == $past(manual_auto_select_bits))
		&& (clock_select == $past(reg_clock_select)))
		else $error("register clock selection not used without pin override");
endmodule
`default_nettype wire

/* cgm_gpio_mux_bench.sv */
// self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module cgm_gpio_mux_bench;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic cfg_wr_en = 1'b0;
	logic [7:0] cfg_wr_data = 8'h00;
	logic pin_output_invert = 1'b0;
	logic pll0_locked = 1'b1;
	logic pll1_locked = 1'b1;
	logic [1:0] clk_los = 2'h0;
	logic [1:0] clock_input_disable = 2'h0;
	logic in_holdover = 1'b0;
	logic [7:0] latched_status = 8'h00;
	logic [7:0] per_condition_irq_mask = 8'h00;
	logic [1:0] selected_clock = 2'h0;
	logic reg_holdover_force = 1'b0;
	logic pll0_vctrl_force_bit = 1'b0;
	logic [1:0] manual_auto_select_bits = 2'h0;
	logic [1:0] reg_clock_select = 2'h0;
	logic [1:0] drv_en = 2'h3;
	logic [1:0] drv_val = 2'h2;
	logic [7:0] cfg_rd_data;
	logic holdover_force, vctrl_force, manual_select_override, strap_done;
	logic [1:0] mode_select, clock_select, strap_value, pin_in, pin_out, pin_oe_n;
	int num_errors = 0;
	int checks = 0;
	always #2.5 clock = !clock;
	cgm_gpio_mux cgm_gpio_mux_i (.clock(clock), .resetn(resetn), .cfg_wr_en(cfg_wr_en),
		.cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data), .pin_output_invert(pin_output_invert),
		.pll0_locked(pll0_locked), .pll1_locked(pll1_locked), .clk_los(clk_los),
		.clock_input_disable(clock_input_disable), .in_holdover(in_holdover),
		.latched_status(latched_status), .per_condition_irq_mask(per_condition_irq_mask),
		.selected_clock(selected_clock), .reg_holdover_force(reg_holdover_force),
		.pll0_vctrl_force_bit(pll0_vctrl_force_bit), .manual_auto_select_bits(manual_auto_select_bits),
		.reg_clock_select(reg_clock_select), .holdover_force(holdover_force), .vctrl_force(vctrl_force),
		.manual_select_override(manual_select_override), .mode_select(mode_select),
		.clock_select(clock_select), .strap_done(strap_done), .strap_value(strap_value),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
	cgm_board_model cgm_board_model_i (.clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.drv_en(drv_en), .drv_val(drv_val), .pin_level(pin_in));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] d);
		@(posedge clock);
		cfg_wr_en <= 1'b1;
		cfg_wr_data <= d;
		@(posedge clock);
		cfg_wr_en <= 1'b0;
	endtask
	task automatic settle();
		repeat (4) @(posedge clock);
		#1;
	endtask
	task automatic pins(input logic [1:0] en, input logic [1:0] v);
		@(posedge clock);
		drv_en <= en;
		drv_val <= v;
	endtask
	task automatic set_pat(input int p, input logic inv);
		@(posedge clock);
		pin_output_invert <= inv;
		pll0_locked <= (p == 0);
		pll1_locked <= (p != 0);
		clk_los <= (p == 0) ? 2'h1 : 2'h2;
		clock_input_disable <= 2'h1;
		in_holdover <= (p == 0);
		latched_status <= 8'h04;
		per_condition_irq_mask <= (p == 0) ? 8'h04 : 8'hfb;
	endtask
	task automatic t_reset();
		pins(2'h0, 2'h0);
		settle();
		chk(cfg_rd_data, 8'hab);
		chk({6'h00, strap_done, 1'b0}, 8'h02);
		chk({6'h00, strap_value}, 8'h02);
		chk({4'h0, pin_oe_n, pin_out}, 8'h03);
		$display("test reset done");
	endtask
	task automatic t_status();
		logic [5:0] tab [2];
		logic e;
		tab[0] = 6'h29;
		tab[1] = 6'h12;
		for (int inv = 0; inv < 2; inv++)
			for (int p = 0; p < 2; p++)
				for (int c = 8; c < 14; c++)
				begin
					set_pat(p, inv[0]);
					wr({c[3:0], c[3:0]});
					settle();
					e = tab[p][c - 8] ^ inv[0];
					chk({4'h0, pin_oe_n, pin_out}, {6'h00, e, e});
				end
		set_pat(0, 1'b0);
		wr(8'h98);
		settle();
		chk({6'h00, pin_out}, 8'h01);
		chk(cfg_rd_data, 8'h98);
		$display("test status done");
	endtask
	task automatic t_reserved();
		logic [7:0] rsv [8];
		rsv = '{8'h00, 8'h33, 8'h44, 8'h55, 8'h66, 8'hee, 8'h70, 8'hf0};
		@(posedge clock);
		reg_holdover_force <= 1'b1;
		pins(2'h3, 2'h3);
		for (int i = 0; i < 8; i++)
		begin
			wr(rsv[i]);
			settle();
			chk({4'h0, pin_oe_n, pin_out}, 8'h0c);
			chk({5'h00, holdover_force, vctrl_force, manual_select_override}, 8'h04);
		end
		$display("test reserved done");
	endtask
	task automatic t_inputs();
		@(posedge clock);
		pll0_vctrl_force_bit <= 1'b1;
		wr(8'h21);
		pins(2'h3, 2'h0);
		settle();
		chk({4'h0, pin_oe_n, holdover_force, vctrl_force}, 8'h0c);
		pins(2'h3, 2'h3);
		settle();
		chk({6'h00, holdover_force, vctrl_force}, 8'h03);
		pins(2'h3, 2'h1);
		settle();
		chk({6'h00, holdover_force, vctrl_force}, 8'h02);
		$display("test inputs done");
	endtask
	task automatic t_manual();
		@(posedge clock);
		manual_auto_select_bits <= 2'h3;
		reg_clock_select <= 2'h1;
		wr(8'hc7);
		pins(2'h3, 2'h1);
		settle();
		chk({pin_oe_n, manual_select_override, mode_select, 1'b0, clock_select}, 8'he1);
		pins(2'h3, 2'h2);
		settle();
		chk({5'h00, manual_select_override, clock_select}, 8'h05);
		pins(2'h3, 2'h0);
		settle();
		chk({5'h00, manual_select_override, clock_select}, 8'h04);
		wr(8'h08);
		settle();
		chk({3'h0, manual_select_override, mode_select, clock_select}, 8'h0d);
		$display("test manual done");
	endtask
	task automatic t_selout();
		pins(2'h0, 2'h0);
		selected_clock <= 2'h1;
		pin_output_invert <= 1'b0;
		wr(8'h3f);
		settle();
		chk({4'h0, pin_oe_n, pin_out}, 8'h01);
		@(posedge clock);
		pin_output_invert <= 1'b1;
		settle();
		chk({4'h0, pin_oe_n, pin_out}, 8'h02);
		$display("test selout done");
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (3000) @(posedge clock);
		num_errors++;
		wrap_up();
	end
	initial
	begin
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		t_reset();
		t_status();
		t_reserved();
		t_inputs();
		t_manual();
		t_selout();
		wrap_up();
	end
endmodule
`default_nettype wire

/* cgm_pin_role.sv */
// role decoder for one general-purpose pin
`timescale 1ns/1ps
`default_nettype none
module cgm_pin_role (
	cgm_role_if.decoder rif
);
	always_comb
	begin
		rif.drive = 1'b0;
		rif.level = 1'b0;
		rif.hold_role = 1'b0;
		rif.vctrl_role = 1'b0;
		case (rif.code)
			cgm_pkg::FN_HOLD_FORCE:
			begin
				rif.hold_role = 1'b1;
			end
			cgm_pkg::FN_VCTRL_FORCE:
			begin
				rif.vctrl_role = 1'b1;
			end
			cgm_pkg::FN_LOCK0:
			begin
				rif.drive = 1'b1;
				rif.level = rif.status[cgm_pkg::ST_LOCK0];
			end
			cgm_pkg::FN_LOCK1:
			begin
				rif.drive = 1'b1;
				rif.level = rif.status[cgm_pkg::ST_LOCK1];
			end
			cgm_pkg::FN_LOCK_BOTH:
			begin
				rif.drive = 1'b1;
				rif.level = rif.status[cgm_pkg::ST_BOTH];
			end
			cgm_pkg::FN_NO_ALARM:
			begin
				rif.drive = 1'b1;
				rif.level = rif.status[cgm_pkg::ST_NO_ALARM];
			end
			cgm_pkg::FN_NO_HOLD:
			begin
				rif.drive = 1'b1;
				rif.level = rif.status[cgm_pkg::ST_NO_HOLD];
			end
			cgm_pkg::FN_IRQ:
			begin
				rif.drive = 1'b1;
				rif.level = rif.status[cgm_pkg::ST_IRQ];
			end
			default:
			begin
				// reserved and global codes: undriven, level ignored
				rif.drive = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

/* cgm_pkg.sv */
// constants shared by the pin function multiplexer
package cgm_pkg;
	localparam int NIB_W = 4;
	localparam int PIN_COUNT = 2;
	localparam int FUNC_W = 8;
	localparam int PIN0_LSB = 0;
	localparam int PIN1_LSB = 4;
	localparam logic [7:0] FUNC_RESET = 8'hab;
	localparam logic [3:0] FN_HOLD_FORCE = 4'h1;
	localparam logic [3:0] FN_VCTRL_FORCE = 4'h2;
	localparam logic [3:0] FN_MAN_SELECT = 4'h7;
	localparam logic [3:0] FN_LOCK0 = 4'h8;
	localparam logic [3:0] FN_LOCK1 = 4'h9;
	localparam logic [3:0] FN_LOCK_BOTH = 4'ha;
	localparam logic [3:0] FN_NO_ALARM = 4'hb;
	localparam logic [3:0] FN_NO_HOLD = 4'hc;
	localparam logic [3:0] FN_IRQ = 4'hd;
	localparam logic [3:0] FN_SEL_OUT = 4'hf;
	localparam int ST_LOCK0 = 0;
	localparam int ST_LOCK1 = 1;
	localparam int ST_BOTH = 2;
	localparam int ST_NO_ALARM = 3;
	localparam int ST_NO_HOLD = 4;
	localparam int ST_IRQ = 5;
	localparam int ST_W = 6;
	localparam logic [1:0] CLKSEL_RSV_MASK = 2'h2;
	localparam logic [1:0] MANUAL_MODE_CODE = 2'h0;
	localparam logic [1:0] STRAP_WAIT = 2'h2;
endpackage

/* cgm_role_if.sv */
// per-pin role code and decoded role flags
`timescale 1ns/1ps
`default_nettype none
interface cgm_role_if;
	logic [cgm_pkg::NIB_W-1:0] code;
	logic [cgm_pkg::ST_W-1:0] status;
	logic drive;
	logic level;
	logic hold_role;
	logic vctrl_role;
	modport decoder (input code, input status, output drive, output level, output hold_role, output vctrl_role);
	modport user (output code, output status, input drive, input level, input hold_role, input vctrl_role);
endinterface
`default_nettype wire
